// [src/szt_zone_timing.sv]
`timescale 1ns/10ps
`include "szt_consts.svh"
module szt_zone_timing #(
  parameter int AW     = 23, // external address width
  parameter int AXI_AW = 4   // register bus address width
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // register bus
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // access requests from the bus interface unit
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_zone_one,
  input  wire logic              req_size16,
  input  wire logic              req_narrow,
  input  wire logic [AW-1:0]     req_addr,
  input  wire logic [15:0]       req_wdata,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_rdata,
  output szt_pkg::szt_state_t    cycle_state,
  // external bus pins
  output logic [AW-1:0]          ext_addr,
  output logic                   zone_one_select,
  output logic                   ext_rd_n,
  output logic                   ext_wr_n,
  output logic                   bus_width_select,
  input  wire logic [15:0]       ext_data_in,
  output logic [15:0]            ext_data_out,
  output logic                   ext_data_oe
);
  import szt_pkg::*;

  // true while a bus cycle drives the pins
  function automatic logic szt_in_access(input szt_state_t s);
    szt_in_access = (s == SZT_ADDR) | (s == SZT_WAIT) | (s == SZT_DATA) |
                    (s == SZT_BWAIT) | (s == SZT_HOLD);
  endfunction

  logic [15:0]   cfg;             // live config from the register file
  logic [15:0]   status;          // state shown to software
  szt_state_t    state_reg;       // current phase
  szt_state_t    state_next;
  logic [2:0]    cnt_reg;         // wait or hold cycles left
  logic [2:0]    cnt_next;
  logic          byte_reg;        // second byte of a split access
  logic          byte_next;
  logic          take;            // data phase of a read in this cycle
  logic          done;            // bus cycle ends in this cycle
  // access attributes frozen when the request is taken
  logic          wr_reg;
  logic          z1_reg;
  logic          split_reg;
  logic          burst_reg;
  logic          bwait_reg;
  logic          fast_reg;
  logic          bw_reg;
  logic          post_reg;
  logic [2:0]    wait_reg;
  logic [1:0]    hold_reg;
  logic [AW-1:0] addr_reg;
  logic [15:0]   wdata_reg;
  // zone history for idle insertion
  logic          last_z1_reg;     // previous cycle was zone one
  logic          post_pend_reg;   // zone one cycle asked for post idle
  // data pin synchroniser and the matching pipeline
  logic [15:0]   din_s1_reg;
  logic [15:0]   din_s2_reg;
  logic [2:0]    take_pipe_reg;
  logic [2:0]    tbyte_pipe_reg;
  logic [2:0]    done_pipe_reg;
  logic [15:0]   rdata_reg;
  // output flops
  logic          req_ready_reg;
  logic          rsp_valid_reg;
  logic [AW-1:0] ext_addr_reg;
  logic          zsel_reg;
  logic          rd_n_reg;
  logic          wr_n_reg;
  logic          bws_reg;
  logic [15:0]   dout_reg;
  logic          doe_reg;

  // register file over the bus
  szt_axil_regs #(.AXI_AW(AXI_AW)) u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status        (status),
    .cfg           (cfg)
  );

  // config field decode
  wire       c_fre  = cfg[`SZT_FRE_BIT];
  wire       c_bw   = cfg[`SZT_BW_BIT];
  wire       c_rbe  = cfg[`SZT_RBE_BIT];
  wire       c_wbr  = cfg[`SZT_WBR_BIT];
  wire       c_post_idle_enable = cfg[`SZT_POST_IDLE_ENABLE_BIT];
  wire       c_preliminary_idle_enable = cfg[`SZT_PRELIMINARY_IDLE_ENABLE_BIT];
  wire [2:0] c_wait = cfg[`SZT_WAIT_MSB:`SZT_WAIT_LSB];
  wire [1:0] c_hold = cfg[`SZT_HOLD_MSB:`SZT_HOLD_LSB];

  // request acceptance and the settings it will run with
  wire accept = (state_reg == SZT_IDLE) & req_ready_reg & req_valid;
  // other zones run a plain cycle; only zone one uses the config
  wire       use_cfg = req_zone_one & ~c_fre;
  wire [2:0] n_wait  = use_cfg ? c_wait : 3'h0;
  wire [1:0] n_hold  = use_cfg ? c_hold : 2'h0;
  wire       n_fast  = req_zone_one & c_fre & ~req_write;
  wire       n_split = req_zone_one & req_size16 & (~c_bw | req_narrow);
  wire       n_burst = n_split & ~req_write & c_rbe & c_bw & ~c_fre;
  wire       n_bwait = n_burst & c_wbr;
  // idle cycles around zone changes
  wire go_post = post_pend_reg & ~req_zone_one;
  wire go_pre  = req_zone_one & c_preliminary_idle_enable & ~last_z1_reg;
  wire last_byte = ~split_reg | byte_reg;

  // phase sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    byte_next  = byte_reg;
    take       = 1'b0;
    done       = 1'b0;
    case (state_reg)
      SZT_IDLE: begin
        if (accept) begin
          byte_next  = 1'b0;
          state_next = go_post ? SZT_POST : (go_pre ? SZT_PRE : SZT_ADDR);
        end
      end
      // idle phases drive nothing, then the address goes out
      SZT_PRE, SZT_POST: begin
        state_next = SZT_ADDR;
      end
      SZT_ADDR: begin
        if (fast_reg) begin
          // single-cycle read, next byte straight after
          take = ~wr_reg;
          if (last_byte) begin
            done       = 1'b1;
            state_next = SZT_IDLE;
          end else begin
            byte_next = 1'b1;
          end
        end else if (wait_reg != 3'h0) begin
          state_next = SZT_WAIT;
          cnt_next   = wait_reg - 3'h1;
        end else begin
          state_next = SZT_DATA;
        end
      end
      SZT_WAIT: begin
        if (cnt_reg == 3'h0) begin
          state_next = SZT_DATA;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      SZT_DATA: begin
        take = ~wr_reg;
        if (burst_reg && !byte_reg) begin
          // burst: second byte skips address and programmed wait; hold comes only after it
          byte_next  = 1'b1;
          state_next = bwait_reg ? SZT_BWAIT : SZT_DATA;
        end else if (hold_reg != 2'h0) begin
          state_next = SZT_HOLD;
          cnt_next   = {1'b0, hold_reg} - 3'h1;
        end else if (last_byte) begin
          done       = 1'b1;
          state_next = SZT_IDLE;
        end else begin
          byte_next  = 1'b1;
          state_next = SZT_ADDR;
        end
      end
      SZT_BWAIT: begin
        state_next = SZT_DATA;
      end
      SZT_HOLD: begin
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else if (last_byte) begin
          done       = 1'b1;
          state_next = SZT_IDLE;
        end else begin
          byte_next  = 1'b1;
          state_next = SZT_ADDR;
        end
      end
      default: begin
        state_next = SZT_IDLE;
      end
    endcase
  end

  // phase registers and the frozen request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SZT_IDLE;
      cnt_reg   <= 3'h0;
      byte_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      z1_reg    <= 1'b0;
      split_reg <= 1'b0;
      burst_reg <= 1'b0;
      bwait_reg <= 1'b0;
      fast_reg  <= 1'b0;
      bw_reg    <= 1'b1;
      post_reg  <= 1'b0;
      wait_reg  <= 3'h0;
      hold_reg  <= 2'h0;
      addr_reg  <= '0;
      wdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      byte_reg  <= byte_next;
      // freezing here keeps a mid-cycle config write out of this cycle
      if (accept) begin
        wr_reg    <= req_write;
        z1_reg    <= req_zone_one;
        split_reg <= n_split;
        burst_reg <= n_burst;
        bwait_reg <= n_bwait;
        fast_reg  <= n_fast;
        bw_reg    <= req_zone_one ? c_bw : 1'b1;
        post_reg  <= req_zone_one & c_post_idle_enable;
        wait_reg  <= n_wait;
        hold_reg  <= n_hold;
        addr_reg  <= req_addr;
        wdata_reg <= req_wdata;
      end
    end
  end

  // zone history: set on cycle end, consumed by the next request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_z1_reg   <= 1'b0;
      post_pend_reg <= 1'b0;
    end else if (done) begin
      last_z1_reg   <= z1_reg;
      post_pend_reg <= post_reg;
    end else if (accept) begin
      post_pend_reg <= 1'b0;
    end
  end

  // data pins pass two flops; read data lines up three cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_s1_reg     <= 16'h0000;
      din_s2_reg     <= 16'h0000;
      take_pipe_reg  <= 3'h0;
      tbyte_pipe_reg <= 3'h0;
      done_pipe_reg  <= 3'h0;
      rdata_reg      <= 16'h0000;
    end else begin
      din_s1_reg     <= ext_data_in;
      din_s2_reg     <= din_s1_reg;
      take_pipe_reg  <= {take_pipe_reg[1:0], take};
      tbyte_pipe_reg <= {tbyte_pipe_reg[1:0], split_reg & byte_reg};
      done_pipe_reg  <= {done_pipe_reg[1:0], done};
      if (take_pipe_reg[2]) begin
        if (tbyte_pipe_reg[2]) begin
          rdata_reg[15:8] <= din_s2_reg[7:0];
        end else begin
          rdata_reg <= bw_reg ? din_s2_reg : {8'h00, din_s2_reg[7:0]};
        end
      end
    end
  end

  // request handshake: no new request while read data is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
    end else begin
      req_ready_reg <= (state_next == SZT_IDLE) & ~done & (done_pipe_reg[1:0] == 2'b00);
      rsp_valid_reg <= done_pipe_reg[2];
    end
  end

  // pins follow the phase one cycle later
  wire       acc_now = szt_in_access(state_reg);
  wire [7:0] wbyte   = byte_reg ? wdata_reg[15:8] : wdata_reg[7:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr_reg <= '0;
      zsel_reg     <= 1'b0;
      rd_n_reg     <= 1'b1;
      wr_n_reg     <= 1'b1;
      bws_reg      <= 1'b1;
      dout_reg     <= 16'h0000;
      doe_reg      <= 1'b0;
    end else begin
      ext_addr_reg <= split_reg ? {addr_reg[AW-1:1], byte_reg} : addr_reg;
      zsel_reg     <= acc_now & z1_reg;
      // read strobe from address on, released for hold
      rd_n_reg     <= ~(acc_now & ~wr_reg & (state_reg != SZT_HOLD));
      wr_n_reg     <= ~(wr_reg & ((state_reg == SZT_WAIT) | (state_reg == SZT_DATA)));
      bws_reg      <= bw_reg;
      dout_reg     <= split_reg ? {8'h00, wbyte} : wdata_reg;
      doe_reg      <= acc_now & wr_reg;
    end
  end

  assign status           = {9'h000, state_reg, byte_reg, post_pend_reg,
                             last_z1_reg, acc_now};
  assign req_ready        = req_ready_reg;
  assign rsp_valid        = rsp_valid_reg;
  assign rsp_rdata        = rdata_reg;
  assign cycle_state      = state_reg;
  assign ext_addr         = ext_addr_reg;
  assign zone_one_select  = zsel_reg;
  assign ext_rd_n         = rd_n_reg;
  assign ext_wr_n         = wr_n_reg;
  assign bus_width_select = bws_reg;
  assign ext_data_out     = dout_reg;
  assign ext_data_oe      = doe_reg;

  // helper run counters for the checks below
  logic [3:0] wrun_reg;
  logic [3:0] hrun_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrun_reg <= 4'h0;
      hrun_reg <= 4'h0;
    end else begin
      wrun_reg <= (state_reg == SZT_WAIT) ? 4'(wrun_reg + 4'h1) : 4'h0;
      hrun_reg <= (state_reg == SZT_HOLD) ? 4'(hrun_reg + 4'h1) : 4'h0;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wait_count: assert property (
    state_reg == SZT_WAIT && state_next != SZT_WAIT |-> 4'(wrun_reg + 4'h1) == {1'b0, wait_reg})
    else $error("wait phase length differs from field");
  a_hold_count: assert property (
    state_reg == SZT_HOLD && state_next != SZT_HOLD |-> 4'(hrun_reg + 4'h1) == {2'b00, hold_reg})
    else $error("hold phase length differs from field");
  a_fast_ignores: assert property (
    accept && req_zone_one && c_fre |=> wait_reg == 3'h0 && hold_reg == 2'h0)
    else $error("fast read kept wait or hold");
  a_wait_after_addr: assert property (
    $rose(state_reg == SZT_WAIT) |-> $past(state_reg) == SZT_ADDR)
    else $error("wait phase not right after address");
  a_hold_data_on: assert property (
    state_reg == SZT_HOLD && wr_reg |=> ext_data_oe && !ext_wr_n == 1'b0)
    else $error("data not driven during hold");
  a_burst_gate: assert property (
    accept && (c_fre || !c_bw || req_write) |=> !burst_reg)
    else $error("burst taken while disabled");
  a_burst_wait: assert property (
    state_reg == SZT_BWAIT |-> burst_reg && bwait_reg && $past(state_reg) == SZT_DATA
      ##1 state_reg == SZT_DATA)
    else $error("burst wait out of place");
  a_fast_one: assert property (
    state_reg == SZT_ADDR && fast_reg |=> state_reg inside {SZT_IDLE, SZT_ADDR})
    else $error("fast read longer than one cycle");
  a_normal_two: assert property (
    state_reg == SZT_ADDR && !fast_reg |=> state_reg != SZT_IDLE)
    else $error("normal cycle shorter than two");
  a_post_idle: assert property (
    accept && go_post |=> state_reg == SZT_POST ##1 state_reg == SZT_ADDR)
    else $error("post idle not inserted");
  a_pre_idle: assert property (
    accept && go_pre && !go_post |=> state_reg == SZT_PRE ##1 state_reg == SZT_ADDR)
    else $error("preliminary idle not inserted");
  a_no_idle: assert property (
    accept && !go_pre && !go_post |=> state_reg == SZT_ADDR)
    else $error("idle cycle inserted without cause");
  a_select_zone: assert property (
    zone_one_select |-> z1_reg)
    else $error("zone one select outside zone one cycle");
  a_width_pin: assert property (
    accept && req_zone_one |=> ##1 bus_width_select == $past(c_bw, 2))
    else $error("bus width pin does not follow config");
  c_burst_wait: cover property (state_reg == SZT_BWAIT);
  c_post_idle: cover property (state_reg == SZT_POST);
  c_fast_split: cover property (fast_reg && split_reg && byte_reg && state_reg == SZT_ADDR);
  c_write_hold: cover property (state_reg == SZT_HOLD && wr_reg);
endmodule

// [src/szt_consts.svh]
`ifndef SZT_CONSTS_SVH
`define SZT_CONSTS_SVH

// register byte offsets
`define SZT_CFG_OFS     4'h0
`define SZT_STAT_OFS    4'h4
// configuration reset value and writable bits
`define SZT_CFG_RESET   16'h069f
`define SZT_CFG_MASK    16'h0eff
// field positions
`define SZT_WAIT_LSB    0
`define SZT_WAIT_MSB    2
`define SZT_HOLD_LSB    3
`define SZT_HOLD_MSB    4
`define SZT_RBE_BIT     5
`define SZT_WBR_BIT     6
`define SZT_BW_BIT      7
`define SZT_POST_IDLE_ENABLE_BIT    9
`define SZT_PRELIMINARY_IDLE_ENABLE_BIT    10
`define SZT_FRE_BIT     11
// bus responses
`define SZT_RESP_OKAY   2'b00
`define SZT_RESP_SLVERR 2'b10
`endif

// [src/szt_pkg.sv]
package szt_pkg;
  // bus cycle phases
  typedef enum logic [2:0] {
    SZT_IDLE  = 3'b000,
    SZT_PRE   = 3'b001,
    SZT_ADDR  = 3'b010,
    SZT_WAIT  = 3'b011,
    SZT_DATA  = 3'b100,
    SZT_BWAIT = 3'b101,
    SZT_HOLD  = 3'b110,
    SZT_POST  = 3'b111
  } szt_state_t;
endpackage

// [src/szt_axil_regs.sv]
`timescale 1ns/10ps
`include "szt_consts.svh"
module szt_axil_regs #(
  parameter int AXI_AW = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [15:0]       status,
  output logic [15:0]            cfg
);
  logic [15:0]       cfg_reg;    // zone one timing config
  logic              aw_got_reg; // address held, awaiting data
  logic              w_got_reg;  // data held, awaiting address
  logic [AXI_AW-1:0] awaddr_reg;
  logic [15:0]       wdata_reg;
  logic [1:0]        wstrb_reg;
  // write fires once both halves are in and no answer is pending
  wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire wr_cfg   = awaddr_reg == `SZT_CFG_OFS;
  wire [15:0] lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [15:0] cfg_wr = (cfg_reg & ~lane_mask) | (wdata_reg & lane_mask & `SZT_CFG_MASK);
  wire ar_hit_cfg = s_axi_araddr == `SZT_CFG_OFS;
  wire ar_hit_st  = s_axi_araddr == `SZT_STAT_OFS;
  wire [15:0] rd_word = ar_hit_cfg ? cfg_reg : (ar_hit_st ? status : 16'h0000);
  assign cfg = cfg_reg;

  // write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg       <= `SZT_CFG_RESET;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= 16'h0000;
      wstrb_reg     <= 2'b00;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SZT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg    <= 1'b1;
        wdata_reg    <= s_axi_wdata[15:0];
        wstrb_reg    <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status is read only: writes there and elsewhere get an error
        s_axi_bresp  <= wr_cfg ? `SZT_RESP_OKAY : `SZT_RESP_SLVERR;
        if (wr_cfg) begin
          cfg_reg <= cfg_wr;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SZT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_word}; // upper half reads zero
      s_axi_rresp   <= (ar_hit_cfg | ar_hit_st) ? `SZT_RESP_OKAY : `SZT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cfg_reset_val: assert property ($past(!aresetn) |-> cfg_reg == `SZT_CFG_RESET)
    else $error("config not at reset value after reset");
  a_reserved_zero: assert property (s_axi_rvalid && $past(ar_hit_cfg && s_axi_arready)
    |-> s_axi_rdata[15:12] == 4'h0 && s_axi_rdata[8] == 1'b0)
    else $error("reserved config bits read non-zero");
  a_cfg_write: assert property (do_write && wr_cfg && wstrb_reg == 2'b11
    |=> cfg_reg == ($past(wdata_reg) & `SZT_CFG_MASK))
    else $error("full config write not stored");
endmodule

// [testbench/szt_ext_mem.sv]
`timescale 1ns/10ps
module szt_ext_mem (
  input  wire logic        aclk,
  input  wire logic [22:0] ext_addr,
  input  wire logic        ext_rd_n,
  output logic      [15:0] ext_data_in
);
  logic [15:0] last_reg = 16'h0; // last value driven
  // data follows the address while read strobe is low; a released bus shows
  // the inverse of the last value so a late sample never looks right
  assign ext_data_in = !ext_rd_n ? {ext_addr[15:8] ^ 8'hc5, ext_addr[7:0] ^ 8'h3c} : ~last_reg;
  always_ff @(posedge aclk) if (!ext_rd_n) last_reg <= ext_data_in;
endmodule

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  import szt_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, req_valid, req_write, req_zone_one, req_size16, req_narrow;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        req_ready, rsp_valid, zone_one_select, ext_rd_n, ext_wr_n, bus_width_select;
  logic        ext_data_oe, bws;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [22:0] req_addr, ext_addr, a;
  logic [15:0] req_wdata, rsp_rdata, ext_data_in, ext_data_out, wd;
  szt_state_t  cycle_state;
  int          num_errors, cmp_count, lat, cfg, lz, lp, el, zz, ww, la[4];
  logic [31:0] sp[4] = '{32'h0, 32'he0, 32'ha0, 32'h80}; // split read setups
  szt_zone_timing szt_zone_timing_inst (.*);
  szt_ext_mem szt_ext_mem_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // width pin as last seen while zone one was selected
  always @(posedge aclk) if (zone_one_select === 1'b1) bws <= bus_width_select;
  // data on the pins as last seen while the write strobe was low
  always @(posedge aclk) if (ext_wr_n === 1'b0) wd <= ext_data_out;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one register write; the leading edge keeps bready from two writes in one step
  task automatic axw(input logic [3:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic axr(input logic [3:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // one access; lat counts cycles from the taking edge to the response
  task automatic acc(input logic z, input logic w, input logic n, input logic [22:0] ad);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_zone_one <= z;
    req_write <= w;
    req_narrow <= n;
    req_addr <= ad;
    req_wdata <= 16'($urandom);
    do @(posedge aclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    lat = 0;
    do begin @(posedge aclk); lat++; end while (rsp_valid !== 1'b1);
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_sim();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {req_valid, req_write, req_zone_one, req_narrow, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, req_addr, req_wdata, lz, lp} = '0;
    s_axi_wstrb = 4'hf;
    req_size16 = 1'b1;
    void'($urandom(29));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(4'h0);
    chk(got, 32'h069f);
    axr(4'h4);
    chk(got, 32'h0);
    axw(4'h0, 32'hffff_ffff);
    axr(4'h0);
    chk(got, 32'h0eff);
    axw(4'h8, 32'h0);
    chk(32'(rs), 32'h2);
    $display("test registers done");
    // random timing: expected phases plus four cycles of response pipe
    for (int i = 0; i < 24; i++) begin
      cfg = ($urandom | 32'h80) & 32'h0eff;
      axw(4'h0, cfg);
      zz = $urandom % 2;
      ww = $urandom % 2;
      a = 23'($urandom) & 23'h7ffffe;
      acc(zz[0], ww[0], 1'b0, a);
      el = !zz[0] ? 2 : cfg[11] ? (ww[0] ? 2 : 1) : 2 + cfg[2:0] + cfg[4:3];
      el += (zz[0] && cfg[10] && lz == 0) || (!zz[0] && lz == 1 && lp == 1);
      chk(32'(lat), 32'(el + 4));
      if (!ww[0]) chk(32'(rsp_rdata), {16'h0, a[15:8] ^ 8'hc5, a[7:0] ^ 8'h3c});
      if (zz[0]) chk(32'(bws), 32'(cfg[7]));
      if (ww[0]) chk(32'(wd), 32'(req_wdata));
      chk(32'(cycle_state), 32'(SZT_IDLE));
      lz = zz[0];
      lp = cfg[9];
    end
    $display("test timing done");
    // byte-split reads: eight-bit bus, burst with and without wait, no burst
    for (int k = 0; k < 4; k++) begin
      axw(4'h0, sp[k]);
      acc(1'b1, 1'b0, k != 0, 23'h000124);
      la[k] = lat;
      chk(32'(rsp_rdata), 32'h1918);
      chk(32'(bws), 32'(sp[k][7]));
    end
    chk(32'(la[1]), 32'(la[2] + 1));
    chk(32'(la[3]), 32'(la[2] + 1));
    $display("test split done");
    end_sim();
  end
endmodule
